// *** rtl/uap_pkg.sv ***
// constants, carriers and state types of the asynchronous serial port
package uap_pkg;

  ////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [4:0] ADDR_DATA = 5'h00;
  localparam logic [4:0] ADDR_CTRL = 5'h04;
  localparam logic [4:0] ADDR_STAT = 5'h08;
  localparam logic [4:0] ADDR_CLR = 5'h0C;
  localparam logic [4:0] ADDR_IEN = 5'h10;

  // serial_control_reg fields
  localparam int CTL_MODE9 = 7;
  localparam int CTL_FIXED = 6;
  localparam int CTL_MCE = 5;
  localparam int CTL_REN = 4;
  localparam int CTL_TB8 = 3;
  localparam int CTL_RB8 = 2;
  localparam int CTL_TI = 1;
  localparam int CTL_RI = 0;
  localparam logic [7:0] CTRL_RESET = 8'h40;

  // event bits of status, clear and enable registers
  localparam int NUM_EV = 5;
  localparam int EV_RI = 0;
  localparam int EV_TI = 1;
  localparam int EV_OVR = 2;
  localparam int EV_FE = 3;
  localparam int EV_COL = 4;

  // frame lengths in bit times, start and stop included
  localparam logic [3:0] FRAME8_BITS = 4'hA;
  localparam logic [3:0] FRAME9_BITS = 4'hB;

  ////////////////////////////////////////////////////////////////////
  typedef enum logic [0:0] {RX_IDLE, RX_RUN} uap_rx_st_e;

  // one received frame as handed to the buffer logic
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
    logic stop;
  } uap_frame_s;

  typedef struct packed {
    logic busy;
    logic half;
    logic [3:0] left;
    logic [10:0] sh;
    logic txd;
    logic done;
  } uap_tx_s;

  typedef struct packed {
    uap_rx_st_e st;
    logic ph;
    logic [3:0] cnt;
    logic [10:0] sh;
    logic prev;
    logic valid;
    uap_frame_s frame;
  } uap_rx_s;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic mode9;
    logic mce;
    logic ren;
    logic tb8;
    logic rb8;
    logic [7:0] rbuf;
    logic [NUM_EV-1:0] ev;
    logic [NUM_EV-1:0] ien;
    logic rxs1;
    logic rxs2;
  } uap_top_s;

endpackage

// *** rtl/uap_tx.sv ***
// transmit shifter of the serial port
module uap_tx (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // timing and control
  input wire logic baud_tick_in,
  input wire logic load_in,
  input wire logic [7:0] data_in,
  input wire logic mode9_in,
  input wire logic ninth_in,
  // status and line
  output logic txd_out,
  output logic busy_out,
  output logic done_out
);

  uap_pkg::uap_tx_s s_ff;
  uap_pkg::uap_tx_s nxt_s;

  ////////////////////////////////////////////////////////////////////
  // a load during a frame restarts it; the top flags that as a collision
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    if (load_in)
    begin
      nxt_s.busy = 1'b1;
      nxt_s.half = 1'b0;
      nxt_s.txd = 1'b0;
      if (mode9_in)
      begin
        nxt_s.left = uap_pkg::FRAME9_BITS;
        nxt_s.sh = {1'b1, ninth_in, data_in, 1'b0};
      end
      else
      begin
        nxt_s.left = uap_pkg::FRAME8_BITS;
        nxt_s.sh = {2'b11, data_in, 1'b0};
      end
    end
    else if (s_ff.busy && baud_tick_in)
    begin
      // two ticks make one bit time
      nxt_s.half = ~s_ff.half;
      if (s_ff.half)
      begin
        nxt_s.sh = {1'b1, s_ff.sh[10:1]};
        nxt_s.left = s_ff.left - 4'h1;
        nxt_s.txd = s_ff.sh[1];
        if (s_ff.left == 4'h2)
        begin
          nxt_s.done = 1'b1;
        end
        if (s_ff.left == 4'h1)
        begin
          nxt_s.busy = 1'b0;
          nxt_s.txd = 1'b1;
        end
      end
    end
  end

  // state register, line idles high
  always_ff @(posedge sys_clk_in)
  begin
    if (!nrst_in)
      s_ff <= '{busy: 1'b0, half: 1'b0, left: 4'h0, sh: 11'h7FF, txd: 1'b1, done: 1'b0};
    else
      s_ff <= nxt_s;
  end

  assign txd_out = s_ff.txd;
  assign busy_out = s_ff.busy;
  assign done_out = s_ff.done;

endmodule

// *** rtl/uap_rx.sv ***
// receive shifter of the serial port
module uap_rx (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // timing and control
  input wire logic baud_tick_in,
  input wire logic rxd_in,
  input wire logic ren_in,
  input wire logic mode9_in,
  // received frame
  output uap_pkg::uap_frame_s frame_out,
  output logic valid_out
);

  uap_pkg::uap_rx_s s_ff;
  uap_pkg::uap_rx_s nxt_s;
  logic [10:0] shifted;
  logic [3:0] last;

  ////////////////////////////////////////////////////////////////////
  // sample once per bit time, first on the first tick after the start edge (at most half a bit later)
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.valid = 1'b0;
    nxt_s.prev = rxd_in;
    shifted = {rxd_in, s_ff.sh[10:1]};
    last = mode9_in ? uap_pkg::FRAME9_BITS - 4'h1 : uap_pkg::FRAME8_BITS - 4'h1;
    case (s_ff.st)
      uap_pkg::RX_IDLE:
      begin
        if (ren_in && s_ff.prev && !rxd_in)
        begin
          nxt_s.st = uap_pkg::RX_RUN;
          nxt_s.ph = 1'b0;
          nxt_s.cnt = 4'h0;
        end
      end
      default:
      begin
        if (!ren_in)
        begin
          nxt_s.st = uap_pkg::RX_IDLE;
        end
        else if (baud_tick_in)
        begin
          nxt_s.ph = ~s_ff.ph;
          if (!s_ff.ph)
          begin
            nxt_s.sh = shifted;
            nxt_s.cnt = s_ff.cnt + 4'h1;
            // a start bit that is high again was a glitch
            if (s_ff.cnt == 4'h0 && rxd_in)
            begin
              nxt_s.st = uap_pkg::RX_IDLE;
            end
            else if (s_ff.cnt == last)
            begin
              nxt_s.st = uap_pkg::RX_IDLE;
              nxt_s.valid = 1'b1;
              nxt_s.frame.stop = rxd_in;
              if (mode9_in)
              begin
                nxt_s.frame.data = shifted[8:1];
                nxt_s.frame.ninth = shifted[9];
              end
              else
              begin
                nxt_s.frame.data = shifted[9:2];
                nxt_s.frame.ninth = rxd_in;
              end
            end
          end
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk_in)
  begin
    if (!nrst_in)
      s_ff <= '{st: uap_pkg::RX_IDLE, ph: 1'b0, cnt: 4'h0, sh: 11'h000, prev: 1'b1,
                valid: 1'b0, frame: 10'h000};
    else
      s_ff <= nxt_s;
  end

  assign frame_out = s_ff.frame;
  assign valid_out = s_ff.valid;

endmodule

// *** rtl/uap_top.sv ***
// asynchronous serial port with register file and interrupt
module uap_top (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // avalon-mm slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // bit timing from the external timer
  input wire logic baud_tick_in,
  // serial line
  input wire logic rxd_in,
  output logic txd_out,
  // interrupt
  output logic irq_out
);

  uap_pkg::uap_top_s s_ff;
  uap_pkg::uap_top_s nxt_s;

  // transfer qualifiers
  logic req;
  logic accept;
  logic wr_lane0;

  // write decodes
  logic wr_data;
  logic wr_ctrl;
  logic wr_clr;
  logic wr_ien;

  // event sources
  logic [uap_pkg::NUM_EV-1:0] ev_set;
  logic [uap_pkg::NUM_EV-1:0] ev_clr;
  logic rx_take;

  // submodule links
  logic tx_busy;
  logic tx_done;
  logic rx_valid;
  uap_pkg::uap_frame_s rx_frame;

  ////////////////////////////////////////////////////////////////////
  // address decoding

  // true when the given offset is addressed
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] offs);
    hit = (addr == offs);
  endfunction

  // serial_control_reg image
  function automatic logic [7:0] ctrl_image(input uap_pkg::uap_top_s s);
    logic [7:0] v;
    v = 8'h00;
    v[uap_pkg::CTL_MODE9] = s.mode9;
    v[uap_pkg::CTL_FIXED] = uap_pkg::CTRL_RESET[uap_pkg::CTL_FIXED];
    v[uap_pkg::CTL_MCE] = s.mce;
    v[uap_pkg::CTL_REN] = s.ren;
    v[uap_pkg::CTL_TB8] = s.tb8;
    v[uap_pkg::CTL_RB8] = s.rb8;
    v[uap_pkg::CTL_TI] = s.ev[uap_pkg::EV_TI];
    v[uap_pkg::CTL_RI] = s.ev[uap_pkg::EV_RI];
    ctrl_image = v;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // bus handshake

  // every access waits exactly one cycle, so readdata can be registered
  assign req = avs_read_in | avs_write_in;
  assign accept = req & ~s_ff.ack;
  assign avs_waitrequest_out = accept;

  // writes take effect on the edge where waitrequest is low
  assign wr_lane0 = avs_write_in & s_ff.ack & avs_byteenable_in[0];

  assign wr_data = wr_lane0 & hit(avs_address_in, uap_pkg::ADDR_DATA);
  assign wr_ctrl = wr_lane0 & hit(avs_address_in, uap_pkg::ADDR_CTRL);
  assign wr_clr = wr_lane0 & hit(avs_address_in, uap_pkg::ADDR_CLR);
  assign wr_ien = wr_lane0 & hit(avs_address_in, uap_pkg::ADDR_IEN);

  ////////////////////////////////////////////////////////////////////
  // receive acceptance

  // the flag must be clear and, when filtering, the ninth bit set
  assign rx_take = rx_valid & ~s_ff.ev[uap_pkg::EV_RI]
                   & (~s_ff.mce | rx_frame.ninth);

  ////////////////////////////////////////////////////////////////////
  // event set and clear terms

  // hardware sets; clearing is left to software
  always_comb
  begin
    ev_set = '0;
    ev_set[uap_pkg::EV_RI] = rx_take;
    ev_set[uap_pkg::EV_TI] = tx_done;
    ev_set[uap_pkg::EV_OVR] = rx_valid & s_ff.ev[uap_pkg::EV_RI];
    ev_set[uap_pkg::EV_FE] = rx_valid & ~rx_frame.stop;
    ev_set[uap_pkg::EV_COL] = wr_data & tx_busy;
    // software may also set the done flags through the control register
    if (wr_ctrl)
    begin
      ev_set[uap_pkg::EV_TI] = tx_done | avs_writedata_in[uap_pkg::CTL_TI];
      ev_set[uap_pkg::EV_RI] = rx_take | avs_writedata_in[uap_pkg::CTL_RI];
    end
  end

  // write-one clear register, or zero written into the control flags
  always_comb
  begin
    ev_clr = '0;
    if (wr_clr)
    begin
      ev_clr = avs_writedata_in[uap_pkg::NUM_EV-1:0];
    end
    if (wr_ctrl)
    begin
      ev_clr[uap_pkg::EV_TI] = ~avs_writedata_in[uap_pkg::CTL_TI];
      ev_clr[uap_pkg::EV_RI] = ~avs_writedata_in[uap_pkg::CTL_RI];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.ack = accept;

    // two-flop synchroniser on the receive pin
    nxt_s.rxs1 = rxd_in;
    nxt_s.rxs2 = s_ff.rxs1;

    // readdata is captured in the waiting cycle
    if (accept && avs_read_in)
    begin
      if (hit(avs_address_in, uap_pkg::ADDR_DATA))
        nxt_s.rdata = {24'h000000, s_ff.rbuf};
      else if (hit(avs_address_in, uap_pkg::ADDR_CTRL))
        nxt_s.rdata = {24'h000000, ctrl_image(s_ff)};
      else if (hit(avs_address_in, uap_pkg::ADDR_STAT))
        nxt_s.rdata = {27'h0000000, s_ff.ev};
      else if (hit(avs_address_in, uap_pkg::ADDR_IEN))
        nxt_s.rdata = {27'h0000000, s_ff.ien};
      else
        nxt_s.rdata = 32'h00000000;
    end

    // control fields; only the two framing modes exist
    if (wr_ctrl)
    begin
      nxt_s.mode9 = avs_writedata_in[uap_pkg::CTL_MODE9];
      nxt_s.mce = avs_writedata_in[uap_pkg::CTL_MCE];
      nxt_s.ren = avs_writedata_in[uap_pkg::CTL_REN];
      nxt_s.tb8 = avs_writedata_in[uap_pkg::CTL_TB8];
      nxt_s.rb8 = avs_writedata_in[uap_pkg::CTL_RB8];
    end

    if (wr_ien)
    begin
      nxt_s.ien = avs_writedata_in[uap_pkg::NUM_EV-1:0];
    end

    // buffer holds the byte while the shifter takes the next one
    if (rx_take)
    begin
      nxt_s.rbuf = rx_frame.data;
      nxt_s.rb8 = rx_frame.ninth;
    end

    // a set in the same cycle as a clear wins
    nxt_s.ev = (s_ff.ev & ~ev_clr) | ev_set;
  end

  ////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge sys_clk_in)
  begin
    if (!nrst_in)
    begin
      s_ff <= '{ack: 1'b0,
                rdata: 32'h00000000,
                mode9: uap_pkg::CTRL_RESET[uap_pkg::CTL_MODE9],
                mce: uap_pkg::CTRL_RESET[uap_pkg::CTL_MCE],
                ren: uap_pkg::CTRL_RESET[uap_pkg::CTL_REN],
                tb8: uap_pkg::CTRL_RESET[uap_pkg::CTL_TB8],
                rb8: uap_pkg::CTRL_RESET[uap_pkg::CTL_RB8],
                rbuf: 8'h00,
                ev: 5'h00,
                ien: 5'h00,
                rxs1: 1'b1,
                rxs2: 1'b1};
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // shifters

  // transmit starts on a data write; both directions run at once
  uap_tx u_tx (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .baud_tick_in(baud_tick_in),
    .load_in(wr_data),
    .data_in(avs_writedata_in[7:0]),
    .mode9_in(s_ff.mode9),
    .ninth_in(s_ff.tb8),
    .txd_out(txd_out),
    .busy_out(tx_busy),
    .done_out(tx_done)
  );

  // receiver reads only the second synchroniser flop
  uap_rx u_rx (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .baud_tick_in(baud_tick_in),
    .rxd_in(s_ff.rxs2),
    .ren_in(s_ff.ren),
    .mode9_in(s_ff.mode9),
    .frame_out(rx_frame),
    .valid_out(rx_valid)
  );

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign avs_readdata_out = s_ff.rdata;

  // level interrupt while any enabled flag stands
  assign irq_out = |(s_ff.ev & s_ff.ien);

endmodule

// *** bench/uap_chk.sv ***
// assertion checker for the serial port top module
module uap_chk (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // register bus
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // line and interrupt
  input wire logic txd_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  ////////////////////////////////////////
  // access steps shared by the properties
  sequence s_data_wr;
    avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0] &&
      avs_address_in == uap_pkg::ADDR_DATA;
  endsequence
  sequence s_rd_done;
    avs_read_in && !avs_waitrequest_out;
  endsequence

  property p_wait_one;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  property p_no_wait_idle;
    !(avs_read_in || avs_write_in) |-> !avs_waitrequest_out;
  endproperty
  property p_tx_start;
    s_data_wr |=> !txd_out;
  endproperty
  property p_ctrl_fixed;
    s_rd_done and avs_address_in == uap_pkg::ADDR_CTRL
      |-> avs_readdata_out[uap_pkg::CTL_FIXED] && avs_readdata_out[31:8] == 24'h000000;
  endproperty
  property p_unmapped;
    s_rd_done and !(avs_address_in inside {5'h00, 5'h04, 5'h08, 5'h0C, 5'h10})
      |-> avs_readdata_out == 32'h00000000;
  endproperty
  property p_rdata_hold;
    !(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out);
  endproperty
  // flags only drop by software, so a falling irq needs a recent write
  property p_irq_fall;
    $fell(irq_out) |-> $past(avs_write_in, 1) || $past(avs_write_in, 2);
  endproperty
  property p_reset_idle;
    $rose(nrst_in) |-> txd_out && !irq_out;
  endproperty

  a_wait_one: assert property (p_wait_one) else $error("wait not one cycle");
  a_no_wait_idle: assert property (p_no_wait_idle) else $error("wait while idle");
  a_tx_start: assert property (p_tx_start) else $error("no start bit");
  a_ctrl_fixed: assert property (p_ctrl_fixed) else $error("control read bad");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped by itself");
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
endmodule

// *** bench/uap_peer.sv ***
// remote serial transceiver facing the port's line pins
module uap_peer #(
  parameter int BIT_CYC = 8
) (
  input wire logic clk_in,
  input wire logic mode9_in,
  input wire logic txd_in,
  output logic rxd_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got_data;
  logic got_ninth;
  int got_cnt;

  // line idles at the mark level
  initial
  begin
    rxd_out = 1'b1;
    got_cnt = 0;
  end

  // one frame, lsb first; b9 is the stop in 8-bit mode, ninth bit in 9-bit
  task automatic send(input logic [7:0] d, input logic b9);
    logic [10:0] f;
    f = {1'b1, b9, d, 1'b0};
    for (int i = 0; i < (mode9_in ? 11 : 10); i++)
    begin
      @(posedge clk_in);
      rxd_out <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk_in);
    end
  endtask

  // sample port frames mid bit; got_ninth is stop or ninth bit
  always
  begin
    @(negedge txd_in);
    repeat (BIT_CYC / 2) @(posedge clk_in);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT_CYC) @(posedge clk_in);
      if (i < 8)
        got_data[i] = txd_in;
      else
        got_ninth = txd_in;
    end
    got_cnt++;
  end
endmodule

// *** bench/tb_top.sv ***
// self-checking bench of the serial port
`define CHK(g, e) chk_val(32'(g), 32'(e))
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TICK_DIV = 4;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h00000000;
  logic [3:0] be = 4'h1;
  logic tick = 1'b0;
  logic mode9 = 1'b0;
  logic [7:0] cdiv = 8'h00;
  logic [31:0] rdat;
  logic [31:0] v;
  logic wait_req;
  logic rxd;
  logic txd;
  logic irq;
  int num_errors = 0;
  int total_checks = 0;

  always #12.5 sys_clk_in = ~sys_clk_in;

  // timer overflow pulse; two of them make one bit time
  always @(posedge sys_clk_in)
  begin
    cdiv <= (cdiv == TICK_DIV - 1) ? 8'h00 : cdiv + 8'h01;
    tick <= (cdiv == TICK_DIV - 1);
  end

  uap_top i_uap_top (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(be),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_req), .baud_tick_in(tick),
    .rxd_in(rxd), .txd_out(txd), .irq_out(irq));
  uap_peer #(.BIT_CYC(2 * TICK_DIV)) i_uap_peer (.clk_in(sys_clk_in), .mode9_in(mode9),
    .txd_in(txd), .rxd_out(rxd));

  ////////////////////////////////////////
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // request held until waitrequest is seen low; one idle edge after release
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    adr <= a;
    wdat <= {24'h000000, d};
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    v = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 50)
    begin
      num_errors++;
      close_out();
    end
    @(posedge sys_clk_in);
  endtask

  // bounded wait for the interrupt line
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400)
    begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n == 400)
    begin
      num_errors++;
      close_out();
    end
  endtask

  ////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    bus(0, uap_pkg::ADDR_CTRL, 0); `CHK(v, 32'h40);
    bus(1, 5'h14, 8'hFF);
    bus(0, 5'h14, 0); `CHK(v, 0);
    bus(1, uap_pkg::ADDR_IEN, 8'h03);
    bus(1, uap_pkg::ADDR_CTRL, 8'h10);
    `CHK(irq, 0);
    $display("test registers done");
    // 8-bit transmit; flag comes before the stop bit is half over
    bus(1, uap_pkg::ADDR_DATA, 8'hA5);
    wait_irq(); `CHK(i_uap_peer.got_cnt, 0);
    repeat (12) @(posedge sys_clk_in);
    `CHK(i_uap_peer.got_data, 8'hA5);
    `CHK(i_uap_peer.got_ninth, 1);
    bus(0, uap_pkg::ADDR_STAT, 0); `CHK(v, 32'h02);
    `CHK(irq, 1);
    bus(1, uap_pkg::ADDR_CLR, 8'h02);
    repeat (2) @(posedge sys_clk_in);
    `CHK(irq, 0);
    $display("test transmit done");
    // receive, then buffer held while the next byte shifts in
    i_uap_peer.send(8'h3C, 1'b1);
    wait_irq();
    fork
      i_uap_peer.send(8'hC3, 1'b1);
    join_none
    bus(0, uap_pkg::ADDR_DATA, 0); `CHK(v, 32'h3C);
    bus(0, uap_pkg::ADDR_CTRL, 0); `CHK(v, 32'h55);
    bus(1, uap_pkg::ADDR_CLR, 8'h01);
    repeat (2) @(posedge sys_clk_in);
    wait_irq();
    repeat (16) @(posedge sys_clk_in);
    bus(0, uap_pkg::ADDR_DATA, 0); `CHK(v, 32'hC3);
    // flag still set: next frame must be dropped
    i_uap_peer.send(8'h99, 1'b1);
    repeat (16) @(posedge sys_clk_in);
    bus(0, uap_pkg::ADDR_DATA, 0); `CHK(v, 32'hC3);
    bus(0, uap_pkg::ADDR_STAT, 0); `CHK(v, 32'h05);
    bus(1, uap_pkg::ADDR_CLR, 8'h1F);
    $display("test receive done");
    // 9-bit transmit with ninth bit set
    mode9 <= 1'b1;
    bus(1, uap_pkg::ADDR_CTRL, 8'h98);
    bus(1, uap_pkg::ADDR_DATA, 8'h5A);
    wait_irq();
    repeat (12) @(posedge sys_clk_in);
    `CHK(i_uap_peer.got_data, 8'h5A);
    `CHK(i_uap_peer.got_ninth, 1);
    bus(1, uap_pkg::ADDR_CLR, 8'h02);
    // filter on: ninth bit low is ignored, high is taken
    bus(1, uap_pkg::ADDR_CTRL, 8'hB0);
    i_uap_peer.send(8'h11, 1'b0);
    repeat (16) @(posedge sys_clk_in);
    bus(0, uap_pkg::ADDR_STAT, 0); `CHK(v, 0);
    i_uap_peer.send(8'h22, 1'b1);
    wait_irq();
    bus(0, uap_pkg::ADDR_DATA, 0); `CHK(v, 32'h22);
    bus(0, uap_pkg::ADDR_CTRL, 0); `CHK(v, 32'hF5);
    $display("test nine bit done");
    // second data write while the shifter is busy flags a collision
    bus(1, uap_pkg::ADDR_CLR, 8'h1F);
    bus(1, uap_pkg::ADDR_DATA, 8'h00);
    bus(1, uap_pkg::ADDR_DATA, 8'h01);
    bus(0, uap_pkg::ADDR_STAT, 0); `CHK(v, 32'h10);
    // lane 0 disabled: control write must be ignored
    be <= 4'h0;
    bus(1, uap_pkg::ADDR_CTRL, 8'h00);
    be <= 4'h1;
    bus(0, uap_pkg::ADDR_CTRL, 0); `CHK(v, 32'hF4);
    $display("test collision done");
    close_out();
  end
endmodule

bind uap_top uap_chk i_uap_chk (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .txd_out(txd_out), .irq_out(irq_out));
